// ### hw/csw_map.svh
// Constants for the cyclic status word bank: addresses, bit positions, resets
`ifndef CSW_MAP_SVH
`define CSW_MAP_SVH

`define CSW_OUT_BASE        14'h5dc
`define CSW_IN_BASE         14'h5eb
`define CSW_UNIT_STRIDE     14'h019
`define CSW_SYS_BIT         15
`define CSW_MSW_BITS        15
`define CSW_B_MEM_OVF       0
`define CSW_B_CERR_LO       1
`define CSW_B_CERR_HI       2
`define CSW_B_ECODE         3
`define CSW_B_BATT          15
`define CSW_B_FATAL         8
`define CSW_B_PORT1         9
`define CSW_B_RUN           15
`define CSW_CERR_LIMIT      9'h0ff
`define CSW_WORD_RESET      16'h0000
`define CSW_NUM_PORTS       3

`endif

// ### hw/csw_pkg.sv
// Types shared by both ends of the cyclic status word bank
package csw_pkg;
  typedef logic [15:0] csw_word_t;
  typedef logic [13:0] csw_addr_t;
  typedef enum {CSW_IDLE, CSW_SEND} csw_state_t;
endpackage

// ### hw/csw_link_if.sv
// Cyclic exchange between host and module: one output word, three input words
`timescale 1ns/10ps
`default_nettype none
interface csw_link_if;
  logic        refresh;
  logic [15:0] out_word;
  logic        out_valid;
  logic [15:0] in_word0;
  logic [15:0] in_word1;
  logic [15:0] in_word2;
  logic        in_valid;

  modport dev
  (
    input  refresh,
    input  out_word,
    input  out_valid,
    output in_word0,
    output in_word1,
    output in_word2,
    output in_valid
  );
  modport host
  (
    output refresh,
    output out_word,
    output out_valid,
    input  in_word0,
    input  in_word1,
    input  in_word2,
    input  in_valid
  );
endinterface
`default_nettype wire

// ### hw/csw_device.sv
// Module end of the cyclic status word bank
//
// What this bank does, across csw_device and csw_host
// RQ1 - Host sends memory switch low bits 00-14
// RQ2 - Output word bit 15 carries no data
// RQ3 - Output word at 1500 plus 25 x unit
// RQ4 - Input words at 1515 plus 25 x unit
// RQ5 - Task bit follows task running
// RQ6 - Memory overflow sets bit 00
// RQ7 - Compile error code up to 255: bit 01
// RQ8 - Compile error code 256 upward: bit 02
// RQ9 - Intermediate code fault sets bit 03
// RQ10 - Vacant bits undefined, host ignores them
// RQ11 - Battery flag holds until recovery, edit, run
// RQ12 - Error code shown, cleared on run
// RQ13 - Fatal stop flag, cleared on run
// RQ14 - Port error flags, cleared on run
// RQ15 - Busy flag while running, compiling, commanding
// RQ16 - Trace disable clears overflow, compile flags
// RQ17 - Following words are user data only
// RQ18 - All words snapshotted together per exchange
`timescale 1ns/10ps
`default_nettype none
`include "csw_map.svh"
module csw_device
  import csw_pkg::*;
#(
  parameter int NUM_TASKS = 16
)
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // Link
  csw_link_if.dev          link,
  // Unit events
  input  wire logic [15:0] task_running_i,
  input  wire logic        mem_overflow_i,
  input  wire logic        compile_err_i,
  input  wire logic [15:0] compile_code_i,
  input  wire logic        ecode_fault_i,
  input  wire logic        batt_low_i,
  input  wire logic        prog_edited_i,
  input  wire logic        prog_run_i,
  input  wire logic        err_valid_i,
  input  wire logic [7:0]  err_code_i,
  input  wire logic        fatal_stop_i,
  input  wire logic [2:0]  port_err_i,
  input  wire logic        busy_run_i,
  input  wire logic        busy_compile_i,
  input  wire logic        busy_command_i,
  input  wire logic        trace_disable_command_i,
  // Host configuration seen by the unit
  output logic      [14:0] mem_switch_o
);

  // Task word is one flag per task, so only a full word is served
  if (NUM_TASKS != 16)
  begin : g_bad_tasks
    $error("csw_device: NUM_TASKS must be 16");
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  logic       mem_ovf;
  logic       cerr_lo;
  logic       cerr_hi;
  logic       ecode;
  logic       batt;
  logic       batt_seen_ok;
  logic [7:0] err_code;
  logic       fatal;
  logic [2:0] port_err;
  logic       cerr_small;

  assign cerr_small = (compile_code_i <= {7'h00, `CSW_CERR_LIMIT});

  // Set wins over the trace-disable clear
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mem_ovf <= 1'b0;
      cerr_lo <= 1'b0;
      cerr_hi <= 1'b0;
    end
    else
    begin
      if (mem_overflow_i)
        mem_ovf <= 1'b1;                                  // see RQ6
      else if (trace_disable_command_i)
        mem_ovf <= 1'b0;                                  // see RQ16
      if (compile_err_i && cerr_small)
        cerr_lo <= 1'b1;                                  // see RQ7
      else if (trace_disable_command_i)
        cerr_lo <= 1'b0;                                  // see RQ16
      if (compile_err_i && !cerr_small)
        cerr_hi <= 1'b1;                                  // see RQ8
      else if (trace_disable_command_i)
        cerr_hi <= 1'b0;                                  // see RQ16
    end
  end

  // No clear for this flag is defined, so a run starts clean
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ecode <= 1'b0;
    else if (ecode_fault_i)
      ecode <= 1'b1;                                      // see RQ9
    else if (prog_run_i)
      ecode <= 1'b0;
  end

  // Battery: needs recovery, then an edit, then a run
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      batt         <= 1'b0;
      batt_seen_ok <= 1'b0;
    end
    else if (batt_low_i)
    begin
      batt         <= 1'b1;                               // see RQ11
      batt_seen_ok <= 1'b0;
    end
    else if (batt && !batt_seen_ok && prog_edited_i)
      batt_seen_ok <= 1'b1;
    else if (batt && batt_seen_ok && prog_run_i)
    begin
      batt         <= 1'b0;                               // see RQ11
      batt_seen_ok <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      err_code <= 8'h00;
    else if (err_valid_i)
      err_code <= err_code_i;                             // see RQ12
    else if (prog_run_i)
      err_code <= 8'h00;                                  // see RQ12
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      fatal <= 1'b0;
    else if (fatal_stop_i)
      fatal <= 1'b1;                                      // see RQ13
    else if (prog_run_i)
      fatal <= 1'b0;                                      // see RQ13
  end

  genvar gp;
  generate
    for (gp = 0; gp < `CSW_NUM_PORTS; gp++)
    begin : g_port
      always_ff @(posedge clock_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          port_err[gp] <= 1'b0;
        else if (port_err_i[gp])
          port_err[gp] <= 1'b1;                           // see RQ14
        else if (prog_run_i)
          port_err[gp] <= 1'b0;                           // see RQ14
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Assembled words and snapshot per exchange
  // ----------------------------------------------------------------
  csw_word_t next_w1;
  csw_word_t next_w2;

  always_comb
  begin
    next_w1                 = `CSW_WORD_RESET;            // see RQ10
    next_w1[`CSW_B_MEM_OVF] = mem_ovf;
    next_w1[`CSW_B_CERR_LO] = cerr_lo;
    next_w1[`CSW_B_CERR_HI] = cerr_hi;
    next_w1[`CSW_B_ECODE]   = ecode;
    next_w1[`CSW_B_BATT]    = batt;
    next_w2                 = `CSW_WORD_RESET;            // see RQ10
    next_w2[7:0]            = err_code;
    next_w2[`CSW_B_FATAL]   = fatal;
    next_w2[`CSW_B_PORT1 +: `CSW_NUM_PORTS] = port_err;
    next_w2[`CSW_B_RUN]     = busy_run_i | busy_compile_i | busy_command_i; // see RQ15
  end

  // Words are only sampled on refresh so the host sees one instant
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      link.in_word0 <= `CSW_WORD_RESET;
      link.in_word1 <= `CSW_WORD_RESET;
      link.in_word2 <= `CSW_WORD_RESET;
      link.in_valid <= 1'b0;
    end
    else
    begin
      link.in_valid <= link.refresh;
      // Status stops at the third word; later words stay user data
      if (link.refresh)                                   // see RQ17
      begin
        link.in_word0 <= task_running_i;                  // see RQ5
        link.in_word1 <= next_w1;                         // see RQ18
        link.in_word2 <= next_w2;                         // see RQ18
      end
    end
  end

  // Bit 15 of the host word is dropped, never passed on
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      mem_switch_o <= 15'h0000;
    else if (link.out_valid)
      mem_switch_o <= link.out_word[`CSW_MSW_BITS-1:0];   // see RQ2
  end

endmodule
`default_nettype wire

// ### hw/csw_host.sv
// Host end of the cyclic status word bank
`timescale 1ns/10ps
`default_nettype none
`include "csw_map.svh"
module csw_host
  import csw_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // Link
  csw_link_if.host         link,
  // Host side
  input  wire logic        refresh_req_i,
  input  wire logic [15:0] mem_switch_i,
  input  wire logic [3:0]  unit_num_i,
  output logic      [13:0] out_addr_o,
  output logic      [13:0] in_addr_o,
  output logic      [15:0] task_word_o,
  output logic      [15:0] fault_word_o,
  output logic      [15:0] run_word_o,
  output logic             words_valid_o
);

  csw_state_t state;
  csw_addr_t  ustride;

  assign ustride = `CSW_UNIT_STRIDE * {10'h000, unit_num_i};

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      out_addr_o <= 14'h0000;
      in_addr_o  <= 14'h0000;
    end
    else
    begin
      out_addr_o <= `CSW_OUT_BASE + ustride;              // see RQ3
      in_addr_o  <= `CSW_IN_BASE + ustride;               // see RQ4
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state          <= CSW_IDLE;
      link.refresh   <= 1'b0;
      link.out_valid <= 1'b0;
      link.out_word  <= `CSW_WORD_RESET;
    end
    else
    begin
      link.refresh   <= 1'b0;
      link.out_valid <= 1'b0;
      case (state)
        CSW_IDLE:
        begin
          if (refresh_req_i)
          begin
            link.out_word  <= {1'b0, mem_switch_i[`CSW_MSW_BITS-1:0]}; // see RQ1, see RQ2
            link.out_valid <= 1'b1;
            link.refresh   <= 1'b1;
            state          <= CSW_SEND;
          end
        end
        CSW_SEND:
        begin
          if (link.in_valid)
            state <= CSW_IDLE;
        end
        default:
          state <= CSW_IDLE;
      endcase
    end
  end

  // Vacant bits are masked off before use
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      task_word_o   <= `CSW_WORD_RESET;
      fault_word_o  <= `CSW_WORD_RESET;
      run_word_o    <= `CSW_WORD_RESET;
      words_valid_o <= 1'b0;
    end
    else
    begin
      words_valid_o <= link.in_valid;
      if (link.in_valid)
      begin
        task_word_o  <= link.in_word0;
        fault_word_o <= link.in_word1 & 16'h800f;         // see RQ10
        run_word_o   <= link.in_word2 & 16'h8fff;         // see RQ10
      end
    end
  end

endmodule
`default_nettype wire

// ### sim/csw_link_monitor.sv
// Link assertions for the cyclic status word bank
`timescale 1ns/10ps
`default_nettype none
module csw_link_monitor
(
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  // Link
  input wire logic        refresh,
  input wire logic [15:0] out_word,
  input wire logic        out_valid,
  input wire logic [15:0] in_word0,
  input wire logic [15:0] in_word1,
  input wire logic [15:0] in_word2,
  input wire logic        in_valid
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  // ----
  // Exchange steps
  // ----
  sequence s_req;
    refresh && out_valid;
  endsequence
  sequence s_ans;
    in_valid && !refresh;
  endsequence
  property p_pair;
    (refresh || out_valid) |-> s_req;
  endproperty
  property p_sys_bit;
    out_valid |-> !out_word[15];
  endproperty
  property p_answer;
    s_req |=> s_ans;
  endproperty
  property p_cause;
    in_valid |-> $past(refresh);
  endproperty
  property p_gap;
    s_req |=> !refresh [*2];
  endproperty
  property p_vacant;
    in_valid |-> (in_word1[14:4] == 11'h000 && in_word2[14:12] == 3'h0);
  endproperty
  // Words change only with a fresh snapshot
  property p_in_hold;
    !in_valid |-> $stable({in_word0, in_word1, in_word2});
  endproperty
  property p_out_hold;
    !out_valid |-> $stable(out_word);
  endproperty
  a_pair: assert property (p_pair) else $error("refresh and out_valid apart");
  a_sys_bit: assert property (p_sys_bit) else $error("reserved bit set");
  a_answer: assert property (p_answer) else $error("no answer");
  a_cause: assert property (p_cause) else $error("answer without request");
  a_gap: assert property (p_gap) else $error("requests too close");
  a_vacant: assert property (p_vacant) else $error("vacant bits set");
  a_in_hold: assert property (p_in_hold) else $error("input words moved");
  a_out_hold: assert property (p_out_hold) else $error("output word moved");
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for both ends of the cyclic status word bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  logic        clock_i, rst_b_i, words_valid_o, refresh_req_i;
  logic [15:0] task_running_i, compile_code_i, mem_switch_i;
  logic        mem_overflow_i, compile_err_i, ecode_fault_i, batt_low_i;
  logic        prog_edited_i, prog_run_i, err_valid_i, fatal_stop_i;
  logic        busy_run_i, busy_compile_i, busy_command_i, trace_disable_command_i;
  logic [7:0]  err_code_i;
  logic [2:0]  port_err_i;
  logic [3:0]  unit_num_i;
  logic [14:0] mem_switch_o;
  logic [13:0] out_addr_o, in_addr_o;
  logic [15:0] task_word_o, fault_word_o, run_word_o;
  int          fails, compares, cycles;

  csw_link_if i_csw_link_if ();
  csw_device i_csw_device (.clock_i, .rst_b_i, .link(i_csw_link_if), .task_running_i,
    .mem_overflow_i, .compile_err_i, .compile_code_i, .ecode_fault_i, .batt_low_i,
    .prog_edited_i, .prog_run_i, .err_valid_i, .err_code_i, .fatal_stop_i, .port_err_i,
    .busy_run_i, .busy_compile_i, .busy_command_i, .trace_disable_command_i, .mem_switch_o);
  csw_host i_csw_host (.clock_i, .rst_b_i, .link(i_csw_link_if), .refresh_req_i,
    .mem_switch_i, .unit_num_i, .out_addr_o, .in_addr_o, .task_word_o, .fault_word_o,
    .run_word_o, .words_valid_o);
  csw_link_monitor i_csw_link_monitor (.clock_i, .rst_b_i,
    .refresh(i_csw_link_if.refresh), .out_word(i_csw_link_if.out_word),
    .out_valid(i_csw_link_if.out_valid), .in_word0(i_csw_link_if.in_word0),
    .in_word1(i_csw_link_if.in_word1), .in_word2(i_csw_link_if.in_word2),
    .in_valid(i_csw_link_if.in_valid));

  // ----
  // Clock, timeout and verdict
  // ----
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic conclude();
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      conclude();
    end
  end

  // ----
  // Access tasks
  // ----
  // Inputs move 1 ns after the edge so the design never races the bench
  task automatic step();
    @(posedge clock_i);
    #1;
  endtask
  // Event inputs are one-cycle pulses
  task automatic fire();
    step();
    {mem_overflow_i, compile_err_i, ecode_fault_i, prog_edited_i, prog_run_i} = '0;
    {err_valid_i, fatal_stop_i, port_err_i, trace_disable_command_i} = '0;
  endtask
  task automatic xch(input logic [15:0] t, input logic [15:0] f, input logic [15:0] r);
    refresh_req_i = 1'b1;
    step();
    refresh_req_i = 1'b0;
    for (int i = 0; i < 8 && words_valid_o !== 1'b1; i++)
      step();
    `CHK("done", 1'b1, words_valid_o)
    `CHK("task", t, task_word_o)
    `CHK("fault", f, fault_word_o)
    `CHK("run", r, run_word_o)
    step();
  endtask

  // ----
  // Scenarios
  // ----
  initial
  begin
    {task_running_i, compile_code_i, mem_switch_i, unit_num_i, refresh_req_i} = '0;
    {mem_overflow_i, compile_err_i, ecode_fault_i, batt_low_i, prog_edited_i} = '0;
    {prog_run_i, err_valid_i, err_code_i, fatal_stop_i, port_err_i} = '0;
    {busy_run_i, busy_compile_i, busy_command_i, trace_disable_command_i} = '0;
    rst_b_i = 1'b0;
    repeat (20) step();
    rst_b_i = 1'b1;
    `CHK("rst_valid", 1'b0, words_valid_o)
    `CHK("rst_msw", 15'h0000, mem_switch_o)
    for (int u = 0; u < 16; u++)
    begin
      unit_num_i = 4'(u);
      step();
      step();
      `CHK("oaddr", 14'(1500 + 25 * u), out_addr_o)
      `CHK("iaddr", 14'(1515 + 25 * u), in_addr_o)
    end
    mem_switch_i = 16'hffff;
    xch(16'h0000, 16'h0000, 16'h0000);
    `CHK("msw", 15'h7fff, mem_switch_o)
    mem_switch_i = 16'h2a5b;
    xch(16'h0000, 16'h0000, 16'h0000);
    `CHK("msw", 15'h2a5b, mem_switch_o)
    for (int k = 0; k < 16; k++)
    begin
      task_running_i = 16'h0001 << k;
      xch(16'h0001 << k, 16'h0000, 16'h0000);
    end
    task_running_i = 16'h0000;
    xch(16'h0000, 16'h0000, 16'h0000);
    // Compile code boundary, then flags accumulate
    compile_err_i = 1'b1;
    compile_code_i = 16'h00ff;
    fire();
    xch(16'h0000, 16'h0002, 16'h0000);
    compile_err_i = 1'b1;
    compile_code_i = 16'h0100;
    mem_overflow_i = 1'b1;
    fire();
    xch(16'h0000, 16'h0007, 16'h0000);
    ecode_fault_i = 1'b1;
    fire();
    xch(16'h0000, 16'h000f, 16'h0000);
    trace_disable_command_i = 1'b1;
    fire();
    xch(16'h0000, 16'h0008, 16'h0000);
    prog_run_i = 1'b1;
    fire();
    xch(16'h0000, 16'h0000, 16'h0000);
    // Battery flag needs recovery, then edit, then run
    batt_low_i = 1'b1;
    step();
    xch(16'h0000, 16'h8000, 16'h0000);
    // An edit while the battery is still low must not count
    prog_edited_i = 1'b1;
    fire();
    batt_low_i = 1'b0;
    prog_run_i = 1'b1;
    fire();
    xch(16'h0000, 16'h8000, 16'h0000);
    prog_edited_i = 1'b1;
    fire();
    prog_run_i = 1'b1;
    fire();
    xch(16'h0000, 16'h0000, 16'h0000);
    err_valid_i = 1'b1;
    err_code_i = 8'hff;
    fatal_stop_i = 1'b1;
    port_err_i = 3'b101;
    fire();
    xch(16'h0000, 16'h0000, 16'h0bff);
    port_err_i = 3'b010;
    fire();
    xch(16'h0000, 16'h0000, 16'h0fff);
    prog_run_i = 1'b1;
    fire();
    xch(16'h0000, 16'h0000, 16'h0000);
    for (int b = 0; b < 3; b++)
    begin
      {busy_command_i, busy_compile_i, busy_run_i} = 3'b001 << b;
      xch(16'h0000, 16'h0000, 16'h8000);
    end
    {busy_command_i, busy_compile_i, busy_run_i} = 3'b000;
    xch(16'h0000, 16'h0000, 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
